// ===== verilog/csor_pkg.sv
// Overview of operation
// - status register answers at 03h and at 83h, same storage both banks
// - add or subtract sets carry on carry out of bit 7, else clears
// - subtract stores carry and half carry as not-borrow
// - one shared prescaler, given to timer or watchdog, never both
// - prescaler given to watchdog makes the timer tick one to one
// - option register fully readable and writable
// - flag-affecting instruction writing status keeps alu zero, half carry, carry
// - software writes to watchdog expiry and sleep entered bits are ignored
`default_nettype none
package csor_pkg;
  localparam logic [7:0] CSOR_STATUS_OFS_B0 = 8'h03;
  localparam logic [7:0] CSOR_STATUS_OFS_B1 = 8'h83;
  localparam logic [7:0] CSOR_OPTION_OFS_B1 = 8'h81;
  localparam logic [7:0] CSOR_OPTION_OFS_B0 = 8'h01;
  localparam int CSOR_BIT_CARRY     = 0;
  localparam int CSOR_BIT_HALF      = 1;
  localparam int CSOR_BIT_ZERO      = 2;
  localparam int CSOR_BIT_SLEEP     = 3;
  localparam int CSOR_BIT_WDOG      = 4;
  localparam int CSOR_BIT_BANK_LOW  = 5;
  localparam int CSOR_BIT_BANK_HIGH = 6;
  localparam int CSOR_BIT_IND_BANK  = 7;
  localparam int CSOR_BIT_PS_ASSIGN = 3;
  localparam int CSOR_BIT_BANK_ADDR = 7;
  localparam logic [7:0] CSOR_STATUS_RST = 8'h18;
  localparam logic [7:0] CSOR_OPTION_RST = 8'hff;
  localparam logic [7:0] CSOR_PS_RATE_MASK = 8'h07;
  localparam logic [7:0] CSOR_PS_TIMER_BASE = 8'h02;
  typedef enum logic [1:0] {
    CSOR_OP_NONE = 2'b01,
    CSOR_OP_ALU  = 2'b10
  } csor_op_t;
endpackage
`default_nettype wire

// ===== verilog/csor_regs.sv
// The plain strobed port was chosen for this implementation.
`default_nettype none
module csor_regs
  import csor_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  // register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // alu result
  input  wire logic       ALU_VALID_I,
  input  wire logic       ALU_SUB_I,
  input  wire logic [7:0] ALU_A_I,
  input  wire logic [7:0] ALU_B_I,
  input  wire logic       FLAG_WR_I,
  input  wire logic       FLAG_Z_I,
  // reset cause events
  input  wire logic       WDOG_EXPIRE_I,
  input  wire logic       SLEEP_ENTER_I,
  input  wire logic       WDOG_CLEAR_I,
  // timer and watchdog clock pulses
  input  wire logic       TIMER_SRC_I,
  input  wire logic       WDOG_SRC_I,
  // user side outputs
  output logic      [7:0] STATUS_O,
  output logic      [7:0] OPTION_O,
  output logic            BANK_SEL_O,
  output logic            TIMER_TICK_O,
  output logic            WDOG_TICK_O
);
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] option;
    logic [7:0] rdata;
    logic [7:0] presc;
    logic       ttick;
    logic       wtick;
  } csor_state_t;

  csor_state_t st_reg;
  csor_state_t st_next;

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] ps_mask;
  logic       hit_status;
  logic       hit_option;
  logic       ps_src;
  logic       ps_out;

  always_comb begin
    st_next = st_reg;
    st_next.ttick = 1'b0;
    st_next.wtick = 1'b0;
    hit_status = (ADDR_I == CSOR_STATUS_OFS_B0) || (ADDR_I == CSOR_STATUS_OFS_B1);
    hit_option = (ADDR_I == CSOR_OPTION_OFS_B1) || (ADDR_I == CSOR_OPTION_OFS_B0);
    if (ALU_SUB_I) begin
      sum = {1'b0, ALU_A_I} + {1'b0, ~ALU_B_I} + 9'h001;
      nib = {1'b0, ALU_A_I[3:0]} + {1'b0, ~ALU_B_I[3:0]} + 5'h01;
    end else begin
      sum = {1'b0, ALU_A_I} + {1'b0, ALU_B_I};
      nib = {1'b0, ALU_A_I[3:0]} + {1'b0, ALU_B_I[3:0]};
    end
    if (WR_I && hit_status) begin
      st_next.status[7:5] = WDATA_I[7:5];
      if (!ALU_VALID_I && !FLAG_WR_I) begin
        st_next.status[2:0] = WDATA_I[2:0];
      end
    end
    if (WR_I && hit_option) begin
      st_next.option = WDATA_I;
    end
    if (ALU_VALID_I) begin
      st_next.status[CSOR_BIT_CARRY] = sum[8];
      st_next.status[CSOR_BIT_HALF]  = nib[4];
      st_next.status[CSOR_BIT_ZERO]  = (sum[7:0] == 8'h00);
    end else if (FLAG_WR_I) begin
      st_next.status[CSOR_BIT_ZERO] = FLAG_Z_I;
    end
    if (WDOG_CLEAR_I) begin
      st_next.status[CSOR_BIT_WDOG]  = 1'b1;
      st_next.status[CSOR_BIT_SLEEP] = 1'b1;
    end
    if (SLEEP_ENTER_I) begin
      st_next.status[CSOR_BIT_SLEEP] = 1'b0;
    end
    if (WDOG_EXPIRE_I) begin
      st_next.status[CSOR_BIT_WDOG] = 1'b0;
    end
    ps_src = st_reg.option[CSOR_BIT_PS_ASSIGN] ? WDOG_SRC_I : TIMER_SRC_I;
    ps_mask = st_reg.option[CSOR_BIT_PS_ASSIGN]
            ? ((8'h01 << st_reg.option[2:0]) - 8'h01)
            : ((CSOR_PS_TIMER_BASE << st_reg.option[2:0]) - 8'h01);
    ps_out = 1'b0;
    if (ps_src) begin
      st_next.presc = st_reg.presc + 8'h01;
      ps_out = ((st_reg.presc & ps_mask) == ps_mask);
    end
    if (WR_I && hit_option) begin
      st_next.presc = 8'h00;
    end
    if (st_reg.option[CSOR_BIT_PS_ASSIGN]) begin
      st_next.ttick = TIMER_SRC_I;
      st_next.wtick = ps_out;
    end else begin
      st_next.ttick = ps_out;
      st_next.wtick = WDOG_SRC_I;
    end
    st_next.rdata = 8'h00;
    if (RD_I && hit_status) begin
      st_next.rdata = st_reg.status;
    end else if (RD_I && hit_option) begin
      st_next.rdata = st_reg.option;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_reg.status <= CSOR_STATUS_RST;
      st_reg.option <= CSOR_OPTION_RST;
      st_reg.rdata  <= 8'h00;
      st_reg.presc  <= 8'h00;
      st_reg.ttick  <= 1'b0;
      st_reg.wtick  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA_O      = st_reg.rdata;
  assign STATUS_O     = st_reg.status;
  assign OPTION_O     = st_reg.option;
  assign BANK_SEL_O   = st_reg.status[CSOR_BIT_BANK_LOW];
  assign TIMER_TICK_O = st_reg.ttick;
  assign WDOG_TICK_O  = st_reg.wtick;
endmodule
`default_nettype wire

// ===== dv/csor_regs_asserts.sv
`default_nettype none
module csor_regs_asserts
  import csor_pkg::*;
(
  // watched ports
  input wire logic       CLK_I, RST_N_I, WR_I, RD_I, ALU_VALID_I, ALU_SUB_I, FLAG_WR_I, FLAG_Z_I, TIMER_SRC_I,
  input wire logic       WDOG_EXPIRE_I, SLEEP_ENTER_I, WDOG_CLEAR_I, BANK_SEL_O, TIMER_TICK_O,
  input wire logic [7:0] ADDR_I, WDATA_I, RDATA_O, ALU_A_I, ALU_B_I, STATUS_O, OPTION_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic st = ADDR_I == CSOR_STATUS_OFS_B0 || ADDR_I == CSOR_STATUS_OFS_B1;
  chk_status_both: assert property (RD_I && st |=> RDATA_O == $past(STATUS_O))
    else $error("status read mismatch");
  chk_add_carry: assert property (ALU_VALID_I && !ALU_SUB_I |=>
    STATUS_O[0] == (9'($past(ALU_A_I)) + 9'($past(ALU_B_I)) > 9'h0ff)) else $error("add carry wrong");
  chk_sub_borrow: assert property (ALU_VALID_I && ALU_SUB_I |=>
    STATUS_O[1:0] == {$past(ALU_A_I[3:0]) >= $past(ALU_B_I[3:0]), $past(ALU_A_I) >= $past(ALU_B_I)})
    else $error("sub borrow wrong");
  chk_tick_cause: assert property (!TIMER_SRC_I |=> !TIMER_TICK_O) else $error("tick without source");
  chk_timer_direct: assert property (OPTION_O[CSOR_BIT_PS_ASSIGN] && TIMER_SRC_I && !WR_I |=> TIMER_TICK_O)
    else $error("timer not one to one");
  chk_option_rw: assert property (WR_I && ADDR_I == CSOR_OPTION_OFS_B1 |=> OPTION_O == $past(WDATA_I))
    else $error("option write lost");
  chk_bank_low: assert property (BANK_SEL_O == STATUS_O[CSOR_BIT_BANK_LOW]) else $error("bank select wrong");
  chk_flag_block: assert property (FLAG_WR_I && WR_I && st |=>
    STATUS_O[2:0] == {$past(FLAG_Z_I), $past(STATUS_O[1:0])}) else $error("flag write not blocked");
  chk_cause_fixed: assert property (!WDOG_EXPIRE_I && !SLEEP_ENTER_I && !WDOG_CLEAR_I |=>
    $stable(STATUS_O[4:3])) else $error("reset cause changed");
endmodule
`default_nettype wire

// ===== dv/csor_alu_model.sv
`default_nettype none
module csor_alu_model (
  input  wire logic       clk_i,
  output var  logic       valid_o, sub_o, flag_wr_o, flag_z_o,
  output var  logic [7:0] a_o, b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {valid_o, sub_o, flag_wr_o, flag_z_o, a_o, b_o} = '0;
  // one-cycle add or subtract result, operands scrambled when idle
  task automatic op(input logic s, input logic [7:0] a, b);
    @(posedge clk_i);
    {valid_o, sub_o, a_o, b_o} <= {1'b1, s, a, b};
    @(posedge clk_i);
    {valid_o, a_o, b_o} <= {1'b0, ~a, ~b};
  endtask
  // other flag-affecting instruction
  task automatic flag(input logic z);
    @(posedge clk_i);
    {flag_wr_o, flag_z_o} <= {1'b1, z};
    @(posedge clk_i);
    {flag_wr_o, flag_z_o} <= {1'b0, ~z};
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, tsrc = 0, valid, sub, fwr, fz, bank, ttick;
  logic       wsrc = 0, wexp = 0, slp = 0, wclr = 0, wtick;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, status, option, a, b;
  int         n_fail = 0, samples_checked = 0;
  always #5 clk = ~clk;
  csor_alu_model alu (.clk_i(clk), .valid_o(valid), .sub_o(sub), .flag_wr_o(fwr), .flag_z_o(fz), .a_o(a), .b_o(b));
  csor_regs dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .ALU_VALID_I(valid), .ALU_SUB_I(sub), .ALU_A_I(a), .ALU_B_I(b), .FLAG_WR_I(fwr),
    .FLAG_Z_I(fz), .WDOG_EXPIRE_I(wexp), .SLEEP_ENTER_I(slp), .WDOG_CLEAR_I(wclr), .TIMER_SRC_I(tsrc),
    .WDOG_SRC_I(wsrc), .STATUS_O(status), .OPTION_O(option), .BANK_SEL_O(bank), .TIMER_TICK_O(ttick),
    .WDOG_TICK_O(wtick));
  task automatic cmp(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, ad, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] ad, exp);
    @(posedge clk);
    {rd, addr} <= {1'b1, ad};
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(rdata, exp);
  endtask
  task automatic tick(input logic exp, input logic exp_w);
    @(posedge clk);
    {tsrc, wsrc} <= 2'b11;
    @(posedge clk);
    {tsrc, wsrc} <= 2'b00;
    @(negedge clk);
    cmp({7'h0, ttick}, {7'h0, exp});
    cmp({7'h0, wtick}, {7'h0, exp_w});
  endtask
  task automatic cause(input logic e, s, c);
    @(posedge clk);
    {wexp, slp, wclr} <= {e, s, c};
    @(posedge clk);
    {wexp, slp, wclr} <= 3'b000;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h03, 8'h18);
    rd_reg(8'h81, 8'hff);
    rd_reg(8'h10, 8'h00);
    wr_reg(8'h83, 8'h27);
    rd_reg(8'h03, 8'h3f);
    cmp({7'h0, bank}, 8'h01);
    alu.op(1'b0, 8'hf0, 8'h20);
    rd_reg(8'h83, 8'h39);
    alu.op(1'b1, 8'h05, 8'h09);
    rd_reg(8'h83, 8'h38);
    alu.op(1'b1, 8'h09, 8'h05);
    rd_reg(8'h83, 8'h3b);
    fork wr_reg(8'h03, 8'h20); alu.flag(1'b1); join
    rd_reg(8'h03, 8'h3f);
    wr_reg(8'h81, 8'h08);
    rd_reg(8'h01, 8'h08);
    tick(1'b1, 1'b1);
    wr_reg(8'h81, 8'h00);
    tick(1'b0, 1'b1);
    cause(1'b1, 1'b1, 1'b0);
    rd_reg(8'h03, 8'h27);
    cause(1'b0, 1'b0, 1'b1);
    rd_reg(8'h83, 8'h3f);
    test_done;
  end
endmodule
bind csor_regs csor_regs_asserts chk (.*);
`default_nettype wire
